// [bench/low_side_driver_control_regs_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module low_side_driver_control_regs_bench;
	import lsd_pkg::*;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready = 1, lpm = 0, rd_pend = 0, hreadyout, hresp, irq;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, ch1_trim, ch2_trim, pwm_source, r;
	logic [1:0]  htrans = 0, pwm_in = 0;
	logic [2:0]  hsize = 2;
	logic [31:0] exp_q [$];
	ch_sense_s   sense [2] = '{4'h0, 4'h0};
	ch_drive_s   drive [2];
	int          error_cnt = 0, check_count = 0;
	integer      seed = 32'h0973;
	always #2.5 hclk = ~hclk;
	low_side_driver_control_regs dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .low_power_mode(lpm), .pwm_in(pwm_in),
		.sense(sense), .drive(drive), .ch1_trim(ch1_trim), .ch2_trim(ch2_trim), .pwm_source(pwm_source),
		.irq(irq));
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Single AHB transfer; a read notes d as its expected data
	task automatic bus(input logic w, input logic [13:0] ofs, input logic [2:0] sz, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1;
		htrans <= HTRANS_NONSEQ;
		haddr <= BANK_BASE | {18'h0, ofs};
		hwrite <= w;
		hsize <= sz;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= d;
		rd_pend <= !w;
		if (!w)
			exp_q.push_back(d);
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd_pend <= 0;
	endtask
	// Read data taken at the data phase edge
	always @(posedge hclk)
		if (rd_pend)
			chk("hrdata", hrdata, exp_q.pop_front());
	task automatic print_verdict;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Whole run needs under a hundred cycles
	initial
	begin
		repeat (5000) @(posedge hclk);
		error_cnt++;
		print_verdict();
	end
	initial
	begin
		repeat (5) @(posedge hclk);
		hresetn <= 1;
		bus(0, OFS_CTRL, 2, 32'h0);
		bus(1, OFS_CTRL, 2, 32'hFFFF_FFFF);
		bus(0, OFS_CTRL, 2, CTRL_MASK);
		chk("edge2", drive[1].fast_edge, 1);
		chk("ol1", drive[0].open_load_detect_en, 1);
		bus(1, OFS_CTRL, 2, 32'h0);
		// Byte write, upper lane carries a decoy
		bus(1, OFS_CTRL + 14'h2, 0, 32'h0105_0000);
		bus(0, OFS_CTRL, 2, 32'h0005_0000);
		chk("sw2", drive[1].switch_on, 1);
		chk("sw1", drive[0].switch_on, 0);
		bus(1, OFS_CTRL, 2, 32'h0107_0000);
		// Random source levels gate the switch
		repeat (8)
		begin
			@(posedge hclk);
			pwm_in <= 2'($random(seed));
			@(negedge hclk);
			chk("pwm2", drive[1].switch_on, pwm_in[1]);
			chk("fast2", drive[1].fast_edge, 1);
		end
		@(posedge hclk);
		pwm_in <= 2'b11;
		lpm <= 1;
		@(negedge hclk);
		chk("lp_sw2", drive[1].switch_on, 0);
		@(posedge hclk);
		lpm <= 0;
		@(negedge hclk);
		chk("wake_sw2", drive[1].switch_on, 1);
		bus(1, OFS_CTRL, 2, 32'h0000_0005);
		bus(1, OFS_IRQ_ENABLE, 2, 32'h80);
		@(posedge hclk);
		sense[0].overcurrent <= 1;
		@(posedge hclk);
		sense[0].overcurrent <= 0;
		@(negedge hclk);
		chk("oc_sw1", drive[0].switch_on, 0);
		chk("irq", irq, 1);
		bus(0, OFS_CTRL, 2, 32'h1);
		bus(0, OFS_IRQ_STATUS, 2, 32'h80);
		bus(1, OFS_IRQ_CLEAR, 2, 32'h80);
		bus(0, OFS_IRQ_STATUS, 2, 32'h0);
		chk("irq_clr", irq, 0);
		r = $random(seed);
		bus(1, OFS_CH1_TRIM, 2, r);
		bus(1, OFS_CH2_TRIM, 2, ~r);
		bus(1, OFS_PWM_SRC, 2, r);
		bus(0, OFS_CH1_TRIM, 2, r);
		bus(0, OFS_CH2_TRIM, 2, ~r);
		bus(0, OFS_PWM_SRC, 2, r & PWM_SRC_MASK);
		chk("trim1", ch1_trim, r);
		bus(1, 14'h0014, 2, 32'hFFFF_FFFF);
		bus(0, 14'h0014, 2, 32'h0);
		@(posedge hclk);
		print_verdict();
	end
endmodule
`default_nettype wire

// [bench/lsd_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module lsd_chk
	import lsd_pkg::*;
#(
	parameter int NUM_CH = 2
)(
	input wire logic              hclk,
	input wire logic              hresetn,
	input wire logic              hreadyout,
	input wire logic              hresp,
	input wire logic              low_power_mode,
	input wire logic [NUM_CH-1:0] pwm_in,
	input wire lsd_pkg::ch_sense_s sense [NUM_CH],
	input wire lsd_pkg::ch_drive_s drive [NUM_CH],
	input wire logic              irq
);
	// One clock domain, reset quiets everything
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_ready_high: assert property (hreadyout) else $error("wait state seen");
	a_resp_okay: assert property (!hresp) else $error("error response seen");
	a_sleep_off1: assert property (low_power_mode |-> !drive[0].switch_on && !drive[0].enable)
		else $error("ch1 driven in low power");
	a_sleep_off2: assert property (low_power_mode |-> !drive[1].switch_on && !drive[1].enable)
		else $error("ch2 driven in low power");
	a_oc_cut: assert property (sense[0].overcurrent |-> !drive[0].switch_on ##1 !drive[0].switch_on)
		else $error("ch1 on through overcurrent");
	a_pwm_gate: assert property (drive[1].pwm_selected && !pwm_in[1] |-> !drive[1].switch_on)
		else $error("ch2 on with source low");
	a_on_needs_en1: assert property (drive[0].switch_on |-> drive[0].enable)
		else $error("ch1 on while disabled");
	a_on_needs_en2: assert property (drive[1].switch_on |-> drive[1].enable)
		else $error("ch2 on while disabled");
	c_pwm_on: cover property (drive[1].switch_on && drive[1].pwm_selected);
	c_irq: cover property (irq);
	c_sleep: cover property (low_power_mode && drive[1].pwm_selected);
endmodule
bind low_side_driver_control_regs lsd_chk #(.NUM_CH(NUM_CH)) u_chk (.hclk(hclk), .hresetn(hresetn),
	.hreadyout(hreadyout), .hresp(hresp), .low_power_mode(low_power_mode), .pwm_in(pwm_in),
	.sense(sense), .drive(drive), .irq(irq));
`default_nettype wire

// [hdl/low_side_driver_control_regs.sv]
// What this block does
// - Every register accepts byte-lane writes without disturbing other bytes.
// - The bank decodes addresses 4001C000 through 4001FFFF.
// - Control register at 0004, interrupt status at 0008.
// - Status clear register at 000C, interrupt enable at 0010.
// - Channel one trim at 0018, source select at 001C, channel two trim at 0020.
// - Control register resets to all zeros.
// - Enable bits at 0 and 16; one enables the channel.
// - Pulse-width mode bits at 1 and 17 gate the on/off bit with the source level.
// - With pulse-width mode clear, the source level is ignored; the on/off bit, with enable set, drives the output.
// - On/off bits at 2 and 18; one turns the switch on.
// - Open-load detect enable bits at 3 and 19.
// - Edge rate bits at 8 and 24; zero slow, one fast.
// - Overcurrent turns the switch off, sets its flag, clears on/off.
// - Drivers off in stop and sleep; configuration kept and restored after wake.
// - Edge rate setting applies in both normal and pulse-width modes.
`timescale 1ns/1ps
`default_nettype none
module low_side_driver_control_regs
	import lsd_pkg::*;
#(
	parameter int NUM_CH = 2
)(
	input  wire logic                 hclk,
	input  wire logic                 hresetn,
	input  wire logic                 hsel,
	input  wire logic [31:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	input  wire logic                 low_power_mode,
	input  wire logic [NUM_CH-1:0]    pwm_in,
	input  wire lsd_pkg::ch_sense_s   sense    [NUM_CH],
	output var lsd_pkg::ch_drive_s    drive    [NUM_CH],
	output logic [31:0]               ch1_trim,
	output logic [31:0]               ch2_trim,
	output logic [31:0]               pwm_source,
	output logic                      irq
);
	import lsd_pkg::*;

	// Control field of one channel; channel two sits CH_STRIDE bits higher
	// so both channels share one decode
	function automatic logic ctrl_bit(input logic [31:0] ctrl, input int ch, input int pos);
		return ctrl[ch*CH_STRIDE + pos];
	endfunction

	// Word decode shared by write strobes and read mux; the low two
	// address bits only pick byte lanes and never move the register
	function automatic logic ofs_hit(input logic [13:0] ofs, input logic [13:0] reg_ofs);
		return (ofs & 14'h3FFC) == reg_ofs;
	endfunction

	// Byte enables from size and low address bits
	// Halfwords pick the lower or upper pair; anything wider is a full word
	// since only 32-bit data paths exist here
	function automatic logic [3:0] lane_mask(input logic [2:0] size, input logic [1:0] a);
		logic [3:0] m;
		m = 4'h0;
		unique case (size)
			3'h0:    m = 4'h1 << a;
			3'h1:    m = a[1] ? 4'hC : 4'h3;
			default: m = 4'hF;
		endcase
		return m;
	endfunction

	// Merge write data into a register through byte lanes and a field mask
	// Masked bits always come back zero, which keeps reserved bits clean
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic [31:0] fmask);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[i*8 +: 8] = wd[i*8 +: 8];
		return r & fmask;
	endfunction

	// Register state
	logic [31:0] ctrl_r;
	logic [31:0] irq_status_r;
	logic [31:0] irq_enable_r;
	logic [31:0] ch1_trim_r;
	logic [31:0] ch2_trim_r;
	logic [31:0] pwm_src_r;
	logic [31:0] hrdata_r;
	// Address phase capture for the data phase
	logic        wr_pend_r;
	logic [13:0] wr_ofs_r;
	logic [3:0]  wr_be_r;
	// Decode and event terms
	logic        in_window;
	logic        wr_req;
	logic        rd_req;
	logic [13:0] req_ofs;
	logic [31:0] status_view;
	logic [NUM_CH-1:0] oc_set;
	logic [31:0] irq_set;
	logic [31:0] irq_clr;
	// Next values, one per register
	logic [31:0] ctrl_nxt;
	logic [31:0] irq_status_nxt;
	logic [31:0] irq_enable_nxt;
	logic [31:0] ch1_trim_nxt;
	logic [31:0] ch2_trim_nxt;
	logic [31:0] pwm_src_nxt;
	logic [31:0] hrdata_nxt;
	// Data phase write strobes, one per register
	logic        wr_ctrl;
	logic        wr_irq_clear;
	logic        wr_irq_enable;
	logic        wr_ch1_trim;
	logic        wr_ch2_trim;
	logic        wr_pwm_src;

	// Slave never inserts wait states
	// Every register is a plain flop, so there is nothing to wait for and
	// errors are never signalled; unmapped words just read zero
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;

	// window decode
	// Outside the window the bank ignores the request entirely, so a stray
	// address can neither write nor disturb the stored read data
	assign in_window = (haddr >= BANK_BASE) && (haddr <= BANK_END);
	assign req_ofs   = haddr[13:0];
	assign rd_req    = hsel && hready && htrans[1] && !hwrite && in_window;

	// Address phase write request; reads are answered from the address phase
	assign wr_req = hsel && htrans[1] && hwrite && in_window;

	// Write pending flag for the data phase; a stalled bus holds it
	// Write data only arrives one cycle later, hence the capture
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wr_pend_r <= 1'b0;
		else if (hready)
			wr_pend_r <= wr_req;
	end

	// Offset of the pending write
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wr_ofs_r <= 14'h0000;
		else if (hready)
			wr_ofs_r <= req_ofs;
	end

	// byte lanes of the pending write
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wr_be_r <= 4'h0;
		else if (hready)
			wr_be_r <= lane_mask(hsize, haddr[1:0]);
	end

	// Hardware events per channel; one cycle of a level sets its flag
	always_comb
	begin
		irq_set = 32'h0000_0000;
		for (int c = 0; c < NUM_CH; c++)
		begin
			irq_set[c*CH_STRIDE + BIT_OC_IS]   = sense[c].overcurrent;
			irq_set[c*CH_STRIDE + BIT_OT_IS]   = sense[c].overtemp;
			// Prewarning flags only, it never shuts the switch down
			irq_set[c*CH_STRIDE + BIT_OTPW_IS] = sense[c].overtemp_prewarn;
			// Open load only flags while its detection is switched on
			irq_set[c*CH_STRIDE + BIT_OL_IS]   = sense[c].open_load && ctrl_bit(ctrl_r, c, BIT_OL_EN);
		end
	end

	// faults that shut a switch down; overtemperature is treated alike
	always_comb
	begin
		oc_set = '0;
		for (int c = 0; c < NUM_CH; c++)
			oc_set[c] = sense[c].overcurrent || sense[c].overtemp;
	end

	// data phase strobes per register word
	// A byte write to offset 0006 still lands in the control word
	assign wr_ctrl       = wr_pend_r && ofs_hit(wr_ofs_r, OFS_CTRL);
	// Status and clear both take write-one-to-clear
	assign wr_irq_clear  = wr_pend_r && (ofs_hit(wr_ofs_r, OFS_IRQ_CLEAR) || ofs_hit(wr_ofs_r, OFS_IRQ_STATUS));
	assign wr_irq_enable = wr_pend_r && ofs_hit(wr_ofs_r, OFS_IRQ_ENABLE);
	assign wr_ch1_trim   = wr_pend_r && ofs_hit(wr_ofs_r, OFS_CH1_TRIM);
	assign wr_ch2_trim   = wr_pend_r && ofs_hit(wr_ofs_r, OFS_CH2_TRIM);
	assign wr_pwm_src    = wr_pend_r && ofs_hit(wr_ofs_r, OFS_PWM_SRC);

	// Write-one-to-clear terms from status or clear register
	assign irq_clr = wr_irq_clear ? merge(32'h0000_0000, hwdata, wr_be_r, IRQ_MASK) : 32'h0000_0000;

	// sticky flags; a new event wins over a clear in the same cycle
	// so a fault that is still present cannot be lost by a late clear
	assign irq_status_nxt = ((irq_status_r & ~irq_clr) | irq_set) & IRQ_MASK;

	// Sticky status register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_status_r <= IRQ_RESET;
		else
			irq_status_r <= irq_status_nxt;
	end

	// Live status bits beside the sticky flags
	// They follow the sense pins and are not sticky; software polls them
	// after clearing a flag to see whether the fault is still there
	always_comb
	begin
		status_view = irq_status_r;
		for (int c = 0; c < NUM_CH; c++)
		begin
			status_view[c*CH_STRIDE + BIT_OTPW_STS] = sense[c].overtemp_prewarn;
			status_view[c*CH_STRIDE + BIT_OT_STS]   = sense[c].overtemp;
			status_view[c*CH_STRIDE + BIT_OL_STS]   = sense[c].open_load;
		end
		status_view = status_view & (IRQ_MASK | STS_MASK);
	end

	// Control next value: bus write through lanes, then hardware clears
	always_comb
	begin
		ctrl_nxt = ctrl_r;
		// control at 0004; reserved bits masked
		if (wr_ctrl)
			ctrl_nxt = merge(ctrl_r, hwdata, wr_be_r, CTRL_MASK);
		// hardware clears on/off and wins over a write in the same cycle
		// so software cannot turn a channel back on through a live fault
		for (int c = 0; c < NUM_CH; c++)
			if (oc_set[c])
				ctrl_nxt[c*CH_STRIDE + BIT_ON_CMD] = 1'b0;
	end

	// Control register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl_r <= CTRL_RESET;
		else
			ctrl_r <= ctrl_nxt;
	end

	// interrupt enable, same layout as the sticky flags
	// Masking a flag leaves it set; only the interrupt line drops
	assign irq_enable_nxt = wr_irq_enable ? merge(irq_enable_r, hwdata, wr_be_r, IRQ_MASK) : irq_enable_r;

	// Interrupt enable register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq_enable_r <= IRQ_RESET;
		else
			irq_enable_r <= irq_enable_nxt;
	end

	// channel one trim, all 32 bits writable
	// The meaning of the trim bits lives in the analog stage
	assign ch1_trim_nxt = wr_ch1_trim ? merge(ch1_trim_r, hwdata, wr_be_r, 32'hFFFF_FFFF) : ch1_trim_r;

	// Channel one trim register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ch1_trim_r <= TRIM_RESET;
		else
			ch1_trim_r <= ch1_trim_nxt;
	end

	// channel two trim, all 32 bits writable
	assign ch2_trim_nxt = wr_ch2_trim ? merge(ch2_trim_r, hwdata, wr_be_r, 32'hFFFF_FFFF) : ch2_trim_r;

	// Channel two trim register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ch2_trim_r <= TRIM_RESET;
		else
			ch2_trim_r <= ch2_trim_nxt;
	end

	// pulse-width source select, only its low field is stored
	// Source decoding is left to the mux outside this bank
	assign pwm_src_nxt = wr_pwm_src ? merge(pwm_src_r, hwdata, wr_be_r, PWM_SRC_MASK) : pwm_src_r;

	// Source select register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pwm_src_r <= PWM_SRC_RESET;
		else
			pwm_src_r <= pwm_src_nxt;
	end

	// read mux; unmapped words in the window read zero
	always_comb
	begin
		hrdata_nxt = 32'h0000_0000;
		if (ofs_hit(req_ofs, OFS_CTRL))
			hrdata_nxt = ctrl_r;
		if (ofs_hit(req_ofs, OFS_IRQ_STATUS))
			hrdata_nxt = status_view;
		// The clear register is write only and reads zero
		if (ofs_hit(req_ofs, OFS_IRQ_CLEAR))
			hrdata_nxt = 32'h0000_0000;
		if (ofs_hit(req_ofs, OFS_IRQ_ENABLE))
			hrdata_nxt = irq_enable_r;
		if (ofs_hit(req_ofs, OFS_CH1_TRIM))
			hrdata_nxt = ch1_trim_r;
		if (ofs_hit(req_ofs, OFS_PWM_SRC))
			hrdata_nxt = pwm_src_r;
		if (ofs_hit(req_ofs, OFS_CH2_TRIM))
			hrdata_nxt = ch2_trim_r;
	end

	// Read data registered at the address phase, so it stands in the data phase
	// and holds until the next read; a write just before still shows old data
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_r <= 32'h0000_0000;
		else if (rd_req)
			hrdata_r <= hrdata_nxt;
	end

	// Level interrupt from unmasked sticky flags; it stays high until
	// software clears the flag or masks it
	assign irq = |(irq_status_r & irq_enable_r);

	// Drive outputs to the power stage; straight from registers and pins so a
	// fault or a sleep request cuts the switch in the same cycle
	always_comb
	begin
		for (int c = 0; c < NUM_CH; c++)
		begin
			// enable, dropped while the device sleeps
			drive[c].enable              = ctrl_bit(ctrl_r, c, BIT_ENABLE) && !low_power_mode;
			drive[c].open_load_detect_en = ctrl_bit(ctrl_r, c, BIT_OL_EN);
			drive[c].fast_edge           = ctrl_bit(ctrl_r, c, BIT_EDGE);
			drive[c].pwm_selected        = ctrl_bit(ctrl_r, c, BIT_PWM_MODE);
			// pulse-width source gates the on command
			// low power forces off while the control bits are kept for wake
			drive[c].switch_on = ctrl_bit(ctrl_r, c, BIT_ENABLE) && ctrl_bit(ctrl_r, c, BIT_ON_CMD)
				&& !low_power_mode && !oc_set[c]
				&& (ctrl_bit(ctrl_r, c, BIT_PWM_MODE) ? pwm_in[c] : 1'b1);
		end
	end

	// Trim and source words go straight to the analog stage and source mux
	assign ch1_trim   = ch1_trim_r;
	assign ch2_trim   = ch2_trim_r;
	assign pwm_source = pwm_src_r;
endmodule
`default_nettype wire

// [hdl/lsd_pkg.sv]
`default_nettype none
package lsd_pkg;
	// Address window of the bank
	localparam logic [31:0] BANK_BASE      = 32'h4001_C000;
	localparam logic [31:0] BANK_END       = 32'h4001_FFFF;
	// Register byte offsets
	localparam logic [13:0] OFS_CTRL       = 14'h0004;
	localparam logic [13:0] OFS_IRQ_STATUS = 14'h0008;
	localparam logic [13:0] OFS_IRQ_CLEAR  = 14'h000C;
	localparam logic [13:0] OFS_IRQ_ENABLE = 14'h0010;
	localparam logic [13:0] OFS_CH1_TRIM   = 14'h0018;
	localparam logic [13:0] OFS_PWM_SRC    = 14'h001C;
	localparam logic [13:0] OFS_CH2_TRIM   = 14'h0020;
	// Control field positions, channel two sits this far above channel one
	localparam int CH_STRIDE    = 16;
	localparam int BIT_ENABLE   = 0;
	localparam int BIT_PWM_MODE = 1;
	localparam int BIT_ON_CMD   = 2;
	localparam int BIT_OL_EN    = 3;
	localparam int BIT_EDGE     = 8;
	// Status field positions (channel one; channel two adds CH_STRIDE)
	localparam int BIT_OTPW_IS  = 4;
	localparam int BIT_OT_IS    = 5;
	localparam int BIT_OL_IS    = 6;
	localparam int BIT_OC_IS    = 7;
	localparam int BIT_OTPW_STS = 12;
	localparam int BIT_OT_STS   = 13;
	localparam int BIT_OL_STS   = 14;
	// Writable masks and reset values
	localparam logic [31:0] CTRL_MASK     = 32'h010F_010F;
	localparam logic [31:0] IRQ_MASK      = 32'h00F0_00F0;
	localparam logic [31:0] STS_MASK      = 32'h7000_7000;
	localparam logic [31:0] PWM_SRC_MASK  = 32'h0000_003F;
	localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
	localparam logic [31:0] IRQ_RESET     = 32'h0000_0000;
	localparam logic [31:0] TRIM_RESET    = 32'h0000_0000;
	localparam logic [31:0] PWM_SRC_RESET = 32'h0000_0000;
	// AHB encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
	localparam logic [1:0] HTRANS_SEQ    = 2'b11;
	// Per-channel power stage feedback and drive
	typedef struct packed {
		logic overcurrent;
		logic overtemp;
		logic overtemp_prewarn;
		logic open_load;
	} ch_sense_s;
	typedef struct packed {
		logic switch_on;
		logic enable;
		logic fast_edge;
		logic open_load_detect_en;
		logic pwm_selected;
	} ch_drive_s;
endpackage
`default_nettype wire
